// ---- hw/exec_pkg.sv ----
`default_nettype none
package exec_pkg;
    // widths of the program counter, data space and apb address
    localparam int PC_W = 21;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int APB_AW = 8;
    localparam int BSR_W = 4;
    localparam int INSTR_W = 16;

    // register byte offsets
    localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] REG_FLAGS = 8'h04;
    localparam logic [APB_AW-1:0] REG_PC = 8'h08;
    localparam logic [APB_AW-1:0] REG_INSTR = 8'h0C;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h10;
    localparam logic [APB_AW-1:0] REG_FSR2 = 8'h14;
    localparam logic [APB_AW-1:0] REG_MEM_ADDR = 8'h18;
    localparam logic [APB_AW-1:0] REG_MEM_DATA = 8'h1C;

    // field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_BSR_LSB = 8;
    localparam int FLAG_Z_BIT = 2;
    localparam int FLAG_OV_BIT = 3;
    localparam int FLAG_N_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TAKEN_BIT = 1;
    localparam int STAT_BAD_BIT = 2;
    localparam int STAT_CYC_LSB = 4;

    // reset values
    localparam logic [BSR_W-1:0] BSR_RST = 4'h0;
    localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [ADDR_W-1:0] FSR2_RST = 12'h000;

    // opcode prefixes
    localparam logic [7:0] OPC_NO_OVERFLOW = 8'hE5;
    localparam logic [7:0] OPC_NONZERO = 8'hE1;
    localparam logic [7:0] OPC_NOT_NEGATIVE = 8'hE7;
    localparam logic [4:0] OPC_ALWAYS = 5'h1A;
    localparam logic [3:0] OPC_SET_BIT = 4'h8;

    // addressing and timing constants
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [7:0] ILO_MAX = 8'h5F;
    localparam logic [BSR_W-1:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_Q1 = 3'b001,
        ST_Q2 = 3'b010,
        ST_Q3 = 3'b011,
        ST_Q4 = 3'b100
    } state_t;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_COND = 3'b001,
        K_ALWAYS = 3'b010,
        K_SETBIT = 3'b011,
        K_BAD = 3'b100
    } kind_t;
endpackage : exec_pkg
`default_nettype wire

// ---- hw/mem_port_if.sv ----
`default_nettype none
// single port into the file register memory
interface mem_port_if;
    logic [exec_pkg::ADDR_W-1:0] addr;
    logic we;
    logic [exec_pkg::DATA_W-1:0] wdata;
    logic [exec_pkg::DATA_W-1:0] rdata;
    modport ctrl (output addr, output we, output wdata, input rdata);
    modport mem (input addr, input we, input wdata, output rdata);
endinterface : mem_port_if
`default_nettype wire

// ---- hw/file_reg_mem.sv ----
`default_nettype none
module file_reg_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    mem_port_if.mem port
);
    import exec_pkg::*;

    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rdata_r;

    // array has no reset so it can map onto plain ram
    always_ff @(posedge pclk) begin
        if (ce && port.we) begin
            cells[port.addr] <= port.wdata;
        end
    end

    // registered read, one edge after the address is presented
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= cells[port.addr];
        end
    end

    assign port.rdata = rdata_r;
endmodule : file_reg_mem
`default_nettype wire

// ---- hw/branch_and_bit_set_exec.sv ----
`default_nettype none
module branch_and_bit_set_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [exec_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [exec_pkg::PC_W-1:0] pc
);
    import exec_pkg::*;

    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic ext_en_r;
    logic [BSR_W-1:0] bsr_r;
    logic [DATA_W-1:0] flags_r;
    logic [PC_W-1:0] pc_r;
    logic [ADDR_W-1:0] fsr2_r;
    logic [ADDR_W-1:0] mem_addr_r;
    logic [INSTR_W-1:0] instr_r;
    state_t state_r;
    kind_t kind_r;
    kind_t kind_w;
    logic nop_cyc_r;
    logic busy_r;
    logic taken_r;
    logic bad_r;
    logic [1:0] cyc_cnt_r;
    logic [ADDR_W-1:0] ea_r;
    logic [ADDR_W-1:0] ea_w;
    logic [DATA_W-1:0] setval_r;
    logic [DATA_W-1:0] mask_w;
    logic [PC_W-1:0] off2_w;
    logic [PC_W-1:0] target_w;
    logic [PC_W-1:0] start_pc_r;
    logic cond_ok_w;
    logic acc_w;
    logic done_w;
    logic wr_w;
    logic start_w;
    logic hit_w;
    logic err_w;
    logic [31:0] rd_w;
    logic exec_w;
    logic [7:0] f_w;

    mem_port_if mp ();

    file_reg_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .port(mp)
    );

    // apb phases: access seen once, answered one edge later
    assign acc_w = psel & penable & ~pready_r;
    assign done_w = psel & penable & pready_r;
    assign wr_w = done_w & pwrite & ~pslverr_r;
    assign start_w = wr_w & (paddr == REG_INSTR);
    assign exec_w = busy_r & ~nop_cyc_r;
    assign f_w = instr_r[7:0];

    // read mux and address decode
    always_comb begin
        hit_w = 1'b1;
        rd_w = 32'h00000000;
        case (paddr)
            REG_CTRL: rd_w = (32'(bsr_r) << CTRL_BSR_LSB)
                | (32'(ext_en_r) << CTRL_EXT_BIT);
            REG_FLAGS: rd_w = 32'(flags_r);
            REG_PC: rd_w = 32'(pc_r);
            REG_INSTR: rd_w = 32'(instr_r);
            REG_STATUS: rd_w = (32'(busy_r) << STAT_BUSY_BIT)
                | (32'(taken_r) << STAT_TAKEN_BIT)
                | (32'(bad_r) << STAT_BAD_BIT)
                | (32'(cyc_cnt_r) << STAT_CYC_LSB);
            REG_FSR2: rd_w = 32'(fsr2_r);
            REG_MEM_ADDR: rd_w = 32'(mem_addr_r);
            REG_MEM_DATA: rd_w = 32'(mp.rdata);
            default: hit_w = 1'b0;
        endcase
    end

    // writes while executing are refused so state cannot shift underfoot
    assign err_w = ~hit_w
        | (busy_r & (pwrite | (paddr == REG_MEM_DATA)));

    // apb answer, registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else if (ce) begin
            if (acc_w) begin
                pready_r <= 1'b1;
                pslverr_r <= err_w;
                prdata_r <= (pwrite | err_w) ? 32'h00000000 : rd_w;
            end else begin
                pready_r <= 1'b0;
                pslverr_r <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_en_r <= 1'b0;
            bsr_r <= BSR_RST;
            fsr2_r <= FSR2_RST;
            mem_addr_r <= '0;
        end else if (ce && wr_w) begin
            if (paddr == REG_CTRL) begin
                ext_en_r <= pwdata[CTRL_EXT_BIT];
                bsr_r <= pwdata[CTRL_BSR_LSB +: BSR_W];
            end
            if (paddr == REG_FSR2) begin
                fsr2_r <= pwdata[ADDR_W-1:0];
            end
            if (paddr == REG_MEM_ADDR) begin
                mem_addr_r <= pwdata[ADDR_W-1:0];
            end
        end
    end

    // flags only change by software, never by the executed instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= FLAGS_RST;
        end else if (ce && wr_w && paddr == REG_FLAGS) begin
            flags_r <= pwdata[DATA_W-1:0];
        end
    end

    // opcode classes; anything else runs as a one-cycle no-effect op
    always_comb begin
        kind_w = K_BAD;
        if (instr_r[15:8] == OPC_NO_OVERFLOW
            || instr_r[15:8] == OPC_NONZERO
            || instr_r[15:8] == OPC_NOT_NEGATIVE) begin
            kind_w = K_COND;
        end else if (instr_r[15:11] == OPC_ALWAYS) begin
            kind_w = K_ALWAYS;
        end else if (instr_r[15:12] == OPC_SET_BIT) begin
            kind_w = K_SETBIT;
        end
    end

    // flag test of the conditional branches
    always_comb begin
        case (instr_r[15:8])
            OPC_NO_OVERFLOW: cond_ok_w = ~flags_r[FLAG_OV_BIT];
            OPC_NONZERO: cond_ok_w = ~flags_r[FLAG_Z_BIT];
            OPC_NOT_NEGATIVE: cond_ok_w = ~flags_r[FLAG_N_BIT];
            default: cond_ok_w = 1'b0;
        endcase
    end

    // doubled signed offset, added to the already advanced pc
    assign off2_w = (kind_r == K_ALWAYS)
        ? {{9{instr_r[10]}}, instr_r[10:0], 1'b0}
        : {{12{instr_r[7]}}, instr_r[7:0], 1'b0};
    assign target_w = pc_r + off2_w;

    // effective data address of the bit set
    always_comb begin
        if (instr_r[8]) begin
            ea_w = {bsr_r, f_w};
        end else if (ext_en_r && f_w <= ILO_MAX) begin
            ea_w = fsr2_r + {4'h0, f_w};
        end else if (f_w <= ILO_MAX) begin
            ea_w = {4'h0, f_w};
        end else begin
            ea_w = {ACCESS_HIGH_BANK, f_w};
        end
    end

    assign mask_w = 8'(8'h01 << instr_r[11:9]);

    // phase sequencer, two passes when a branch is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            nop_cyc_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (start_w) begin
                        state_r <= ST_Q1;
                        nop_cyc_r <= 1'b0;
                        busy_r <= 1'b1;
                    end
                end
                ST_Q1: state_r <= ST_Q2;
                ST_Q2: state_r <= ST_Q3;
                ST_Q3: state_r <= ST_Q4;
                ST_Q4: begin
                    if (!nop_cyc_r && taken_r) begin
                        state_r <= ST_Q1;
                        nop_cyc_r <= 1'b1;
                    end else begin
                        state_r <= ST_IDLE;
                        nop_cyc_r <= 1'b0;
                        busy_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    nop_cyc_r <= 1'b0;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // instruction capture and q1 decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r <= '0;
            start_pc_r <= PC_RST;
            kind_r <= K_NONE;
            ea_r <= '0;
            bad_r <= 1'b0;
        end else if (ce) begin
            if (start_w) begin
                instr_r <= pwdata[INSTR_W-1:0];
                start_pc_r <= pc_r;
            end
            if (exec_w && state_r == ST_Q1) begin
                kind_r <= kind_w;
                ea_r <= ea_w; // presented in q2 for the read
                bad_r <= (kind_w == K_BAD);
            end
        end
    end

    // q3 process: branch decision and modified byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_r <= 1'b0;
            setval_r <= 8'h00;
            cyc_cnt_r <= 2'h0;
        end else if (ce && exec_w) begin
            if (state_r == ST_Q1) begin
                taken_r <= 1'b0;
            end
            if (state_r == ST_Q3) begin
                taken_r <= (kind_r == K_ALWAYS)
                    | ((kind_r == K_COND) & cond_ok_w);
                setval_r <= mp.rdata | mask_w;
            end
            if (state_r == ST_Q4) begin
                cyc_cnt_r <= taken_r ? CYC_TWO : CYC_ONE;
            end
        end
    end

    // program counter: fetch advance in q1, branch write in q4
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_r <= PC_RST;
        end else if (ce) begin
            if (wr_w && paddr == REG_PC) begin
                pc_r <= pwdata[PC_W-1:0];
            end else if (exec_w && state_r == ST_Q1) begin
                pc_r <= pc_r + PC_STEP;
            end else if (exec_w && state_r == ST_Q4 && taken_r) begin
                pc_r <= target_w;
            end
        end
    end

    // memory port: executor owns it while busy, software otherwise
    assign mp.addr = busy_r ? ea_r : mem_addr_r;
    assign mp.we = (exec_w & (state_r == ST_Q4) & (kind_r == K_SETBIT))
        | (wr_w & (paddr == REG_MEM_DATA));
    assign mp.wdata = busy_r ? setval_r : pwdata[DATA_W-1:0];

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pc = pc_r;

    // checks; a frozen clock enable abandons any check in flight
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !ce);

    no_ovf_branch_a: assert property (
        (state_r == ST_Q3 && exec_w && kind_r == K_COND
            && instr_r[15:8] == OPC_NO_OVERFLOW)
        |=> (taken_r == !flags_r[FLAG_OV_BIT]))
        else $error("overflow-clear branch decision wrong");

    nonzero_branch_a: assert property (
        (state_r == ST_Q3 && exec_w && kind_r == K_COND
            && instr_r[15:8] == OPC_NONZERO)
        |=> (taken_r == !flags_r[FLAG_Z_BIT]))
        else $error("zero-clear branch decision wrong");

    not_neg_skip_a: assert property (
        (state_r == ST_Q4 && exec_w && kind_r == K_COND
            && instr_r[15:8] == OPC_NOT_NEGATIVE && flags_r[FLAG_N_BIT])
        |=> (state_r == ST_IDLE && pc_r == start_pc_r + PC_STEP))
        else $error("negative-clear branch did not fall through");

    always_taken_a: assert property (
        (state_r == ST_Q3 && exec_w && kind_r == K_ALWAYS) |=> taken_r)
        else $error("unconditional branch not taken");

    target_sum_a: assert property (
        (state_r == ST_Q4 && exec_w && taken_r)
        |=> (pc_r == $past(pc_r) + off2_w))
        else $error("branch target not pc plus doubled offset");

    target_abs_a: assert property (
        (state_r == ST_Q4 && exec_w && taken_r)
        |=> (pc_r == start_pc_r + PC_STEP + off2_w))
        else $error("branch target not address plus two plus 2n");

    cond_cycles_a: assert property (
        (state_r == ST_Q4 && exec_w && kind_r == K_COND && taken_r)
        |=> (nop_cyc_r && state_r == ST_Q1) ##3
            (state_r == ST_Q4) ##1 (state_r == ST_IDLE))
        else $error("taken conditional branch cycle count wrong");

    cond_single_a: assert property (
        (state_r == ST_Q4 && exec_w && kind_r == K_COND && !taken_r)
        |=> (state_r == ST_IDLE))
        else $error("untaken conditional branch not one cycle");

    always_cycles_a: assert property (
        (state_r == ST_Q4 && exec_w && kind_r == K_ALWAYS)
        |=> (nop_cyc_r && busy_r) [*4] ##1 (state_r == ST_IDLE))
        else $error("unconditional branch not two cycles");

    flags_hold_a: assert property (
        busy_r |=> $stable(flags_r))
        else $error("flags changed during execution");

    bit_write_a: assert property (
        (state_r == ST_Q4 && exec_w && kind_r == K_SETBIT)
        |-> (mp.we && mp.addr == ea_r && mp.wdata == (mp.rdata | mask_w)))
        else $error("bit set write-back wrong");

    bank_select_a: assert property (
        (state_r == ST_Q2 && exec_w && kind_r == K_SETBIT && instr_r[8])
        |-> (ea_r == {bsr_r, f_w}))
        else $error("banked address wrong");

    indexed_mode_a: assert property (
        (state_r == ST_Q2 && exec_w && kind_r == K_SETBIT && !instr_r[8]
            && ext_en_r && f_w <= ILO_MAX)
        |-> (ea_r == 12'(fsr2_r + {4'h0, f_w})))
        else $error("indexed literal offset address wrong");

    setbit_phases_a: assert property (
        (state_r == ST_Q2 && exec_w && kind_r == K_SETBIT)
        |=> (state_r == ST_Q3) ##1 (state_r == ST_Q4 && !taken_r)
            ##1 (state_r == ST_IDLE && !busy_r))
        else $error("bit set did not finish in one cycle");
endmodule : branch_and_bit_set_exec
`default_nettype wire

// ---- bench/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import exec_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [PC_W-1:0] pc;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    branch_and_bit_set_exec branch_and_bit_set_exec_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pc(pc)
    );

    // 25 MHz
    always #20 pclk = ~pclk;

    // hang guard: the whole run needs a few thousand cycles at most
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check(e, 1'b0);
    endtask : wr

    task automatic rd(input logic [APB_AW-1:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd

    // issue one instruction and poll until the engine is idle again
    task automatic exec(input logic [15:0] ins, output logic [31:0] st);
        int n;
        wr(REG_INSTR, {16'h0, ins});
        n = 0;
        do begin
            rd(REG_STATUS, st);
            n++;
        end while (st[STAT_BUSY_BIT] !== 1'b0 && n < 50);
    endtask : exec

    // own address plus two plus twice the sign-extended offset
    function automatic logic [PC_W-1:0] target(input logic [PC_W-1:0] h,
                                               input logic [10:0] n);
        return h + PC_STEP + {{(PC_W-12){n[10]}}, n, 1'b0};
    endfunction : target

    initial begin
        logic [7:0] opc [3];
        int fbit [3];
        logic [31:0] st;
        logic [31:0] r;
        logic [PC_W-1:0] here;
        logic [PC_W-1:0] exp;
        logic [7:0] fl;
        logic [7:0] n;
        logic [10:0] nl;
        logic [7:0] f;
        logic [7:0] old;
        logic [3:0] bank_select_register;
        logic [ADDR_W-1:0] fsr2;
        logic [ADDR_W-1:0] ad;
        logic a;
        logic ext;
        logic flag;
        logic e;
        opc = '{OPC_NO_OVERFLOW, OPC_NONZERO, OPC_NOT_NEGATIVE};
        fbit = '{FLAG_OV_BIT, FLAG_Z_BIT, FLAG_N_BIT};
        void'($urandom(32'h3bd78086));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        check(pc, PC_RST);
        rd(REG_PC, r);
        check(r, 32'h0);
        rd(REG_STATUS, r);
        check(r, 32'h0);
        // conditional branches: boundary offsets, then random ones
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 6; k++) begin
                n = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'($urandom);
                flag = (k >= 2) && k[0];
                here = PC_W'($urandom) & ~PC_W'(1);
                fl = 8'($urandom);
                fl[fbit[i]] = flag;
                wr(REG_PC, 32'(here));
                wr(REG_FLAGS, {24'h0, fl});
                exec({opc[i], n}, st);
                exp = flag ? here + PC_STEP : target(here, {{3{n[7]}}, n});
                check(pc, exp);
                check(st[STAT_TAKEN_BIT], !flag);
                exp = flag ? CYC_ONE : CYC_TWO;
                check(st[STAT_CYC_LSB +: 2], exp[1:0]);
                rd(REG_FLAGS, r);
                check(r, {24'h0, fl});
            end
        end
        // unconditional branch across the full offset range
        for (int k = 0; k < 4; k++) begin
            nl = (k == 0) ? 11'h400 : (k == 1) ? 11'h3FF : 11'($urandom);
            here = PC_W'($urandom) & ~PC_W'(1);
            fl = 8'($urandom);
            wr(REG_PC, 32'(here));
            wr(REG_FLAGS, {24'h0, fl});
            exec({OPC_ALWAYS, nl}, st);
            check(pc, target(here, nl));
            check(st[STAT_CYC_LSB +: 2], CYC_TWO);
            rd(REG_FLAGS, r);
            check(r, {24'h0, fl});
        end
        // bit set in every addressing mode, edges of the 5Fh limit first
        for (int k = 0; k < 8; k++) begin
            bank_select_register = 4'($urandom);
            fsr2 = ADDR_W'($urandom);
            ext = (k[1:0] == 2'd3) ? 1'b1 : (k[1:0] == 2'd1) ? 1'b0
                                                            : 1'($urandom);
            a = (k[1:0] == 2'd0);
            if (k[1:0] == 2'd2) begin
                f = (k < 4) ? 8'h60 : 8'(8'h60 + $urandom % 160);
            end else begin
                f = (k < 4) ? ILO_MAX : 8'($urandom % 96);
            end
            if (a) begin
                ad = {bank_select_register, f};
            end else if (f > ILO_MAX) begin
                ad = {ACCESS_HIGH_BANK, f};
            end else begin
                ad = ext ? ADDR_W'(fsr2 + f) : ADDR_W'(f);
            end
            old = 8'($urandom);
            fl = 8'($urandom);
            here = PC_W'($urandom) & ~PC_W'(1);
            wr(REG_CTRL, {20'h0, bank_select_register, 7'h0, ext});
            wr(REG_FSR2, 32'(fsr2));
            wr(REG_FLAGS, {24'h0, fl});
            wr(REG_PC, 32'(here));
            wr(REG_MEM_ADDR, 32'(ad));
            wr(REG_MEM_DATA, {24'h0, old});
            exec({OPC_SET_BIT, k[2:0], a, f}, st);
            check(st[STAT_CYC_LSB +: 2], CYC_ONE);
            check(pc, here + PC_STEP);
            rd(REG_MEM_DATA, r);
            old = old | (8'h01 << k[2:0]);
            check(r, {24'h0, old});
            rd(REG_FLAGS, r);
            check(r, {24'h0, fl});
        end
        // unknown opcode: one cycle, only the pc advances
        here = PC_W'($urandom) & ~PC_W'(1);
        wr(REG_PC, 32'(here));
        exec(16'hF000, st);
        check(st[STAT_BAD_BIT], 1'b1);
        check(st[STAT_CYC_LSB +: 2], CYC_ONE);
        check(pc, here + PC_STEP);
        // unmapped and unaligned addresses are refused
        apb(1'b0, 8'h20, 32'h0, r, e);
        check(e, 1'b1);
        apb(1'b1, 8'h02, 32'h0, r, e);
        check(e, 1'b1);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
